// File: iqgom_pkg.sv
package iqgom_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Bus widths
  localparam int IQGOM_ADDR_W = 8;
  localparam int IQGOM_DATA_W = 32;
  localparam int IQGOM_SAMP_W = 16;

  ////////////////////////////////////////////////////////////////////////////
  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_C_OFS = 6'h0A;
  localparam logic [5:0] IDX_D_OFS = 6'h0B;
  localparam logic [5:0] IDX_A_GAIN = 6'h0C;
  localparam logic [5:0] IDX_MIX_B_GAIN = 6'h0D;
  localparam logic [5:0] IDX_C_GAIN = 6'h0E;
  localparam logic [5:0] IDX_AUTOSYNC = 6'h1E;
  localparam logic [5:0] IDX_ACT_C_OFS = 6'h20;
  localparam logic [5:0] IDX_ACT_D_OFS = 6'h21;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int OFS_MSB = 12;
  localparam int GAIN_MSB = 10;
  localparam int GAIN_FRAC = 10;
  localparam int MIX_LSB = 12;
  localparam int MIX_MSB = 15;
  localparam int AUTOSYNC_BIT = 0;
  localparam int MIX_P8 = 3;
  localparam int MIX_P4 = 2;
  localparam int MIX_P2 = 1;
  localparam int MIX_M4 = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [12:0] OFS_RST = 13'h0000;
  localparam logic [10:0] GAIN_RST = 11'h400;
  localparam logic [3:0] MIX_RST = 4'h0;
  localparam logic AUTOSYNC_RST = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Coarse mixer phase steps in eighths of a turn, and cos(45 deg) in Q15
  localparam logic [2:0] STEP_P8 = 3'h1;
  localparam logic [2:0] STEP_P4 = 3'h2;
  localparam logic [2:0] STEP_P2 = 3'h4;
  localparam logic [2:0] STEP_M4 = 3'h6;
  localparam logic signed [17:0] COS45_Q15 = 18'sh05A82;
  localparam int COS45_SHIFT = 15;

  // Register select decoded from the bus address
  typedef enum {
    SEL_C_OFS, SEL_D_OFS, SEL_A_GAIN, SEL_MIX_B_GAIN, SEL_C_GAIN,
    SEL_AUTOSYNC, SEL_ACT_C_OFS, SEL_ACT_D_OFS, SEL_NONE
  } iqgom_sel_t;

  // Clamp a wide signed value to the sample width
  function automatic logic signed [15:0] iqgom_sat(input logic signed [19:0] v);
    if (v > 20'sh07FFF) begin
      return 16'sh7FFF;
    end else if (v < -20'sh08000) begin
      return -16'sh8000;
    end else begin
      return v[15:0];
    end
  endfunction

endpackage

// File: iqgom_chan.sv
`timescale 1ns/1ps
module iqgom_chan import iqgom_pkg::*; (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Correction settings
  input wire logic [10:0] gain,
  input wire logic signed [12:0] offset,
  // Sample stream
  input wire logic signed [15:0] sample,
  input wire logic sample_valid,
  output logic signed [15:0] result,
  output logic result_valid
);

  typedef struct packed {
    logic signed [15:0] res;
    logic vld;
  } iqgom_chan_st_t;

  iqgom_chan_st_t q, d;
  logic signed [27:0] prod;
  logic signed [19:0] sum;

  ////////////////////////////////////////////////////////////////////////////
  // Gain is Q1.10 unsigned, so drop ten fraction bits before the offset add
  always_comb begin
    d = q;
    prod = 28'(sample) * 28'($signed({1'b0, gain}));
    sum = 20'(prod >>> GAIN_FRAC) + 20'(offset);
    d.vld = sample_valid;
    if (sample_valid) begin
      d.res = iqgom_sat(sum);
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign result = q.res;
  assign result_valid = q.vld;

endmodule

// File: iqgom_regs.sv
// Contract
// - Channel C offset is a 13-bit signed LSB value in bits 12:0, reset zero.
// - With autosync enabled, a write to the channel C offset raises a sync event.
// - A sync event loads both stored C and D offsets into the datapath together.
// - A D offset write alone only changes the stored value, not the datapath.
// - Channel D offset is a 13-bit signed LSB value in bits 12:0, reset zero.
// - Channel A gain is an 11-bit unsigned factor from 0 to 1.9990.
// - Gain words have the binary point between bits 9 and 10.
// - Channel B gain sits in bits 10:0 of the register shared with the mixer.
// - Channel C gain is an 11-bit unsigned factor in the same format.
// - Each gain register resets to 0x0400, unity gain.
// - Mixer bits reset to zero; 15 is +fs/8, 14 fs/4, 13 fs/2, 12 -fs/4.
// - Several mixer bits cascade into a total shift of n times fs/8.
// - Reserved bits reset to zero and stay zero.
`timescale 1ns/1ps
module iqgom_regs import iqgom_pkg::*; (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // External sync request for the CD offsets
  input wire logic sync_in,
  // Input samples
  input wire logic signed [15:0] sample_a_in,
  input wire logic signed [15:0] sample_b_in,
  input wire logic signed [15:0] sample_c_in,
  input wire logic signed [15:0] sample_d_in,
  input wire logic sample_valid_in,
  // Corrected and mixed samples
  output logic signed [15:0] sample_a_out,
  output logic signed [15:0] sample_b_out,
  output logic signed [15:0] sample_c_out,
  output logic signed [15:0] sample_d_out,
  output logic sample_valid_out,
  output logic offset_loaded
);

  typedef struct packed {
    logic [12:0] chan_c_offset_value;
    logic [12:0] chan_d_offset_value;
    logic [10:0] chan_a_gain_value;
    logic [10:0] chan_b_gain_value;
    logic [10:0] chan_c_gain_value;
    logic [3:0] cmix;
    logic autosync;
    logic [12:0] act_c_ofs;
    logic [12:0] act_d_ofs;
    logic [2:0] phase;
    logic signed [15:0] out_a;
    logic signed [15:0] out_b;
    logic signed [15:0] out_c;
    logic signed [15:0] out_d;
    logic out_vld;
    logic loaded;
    logic [31:0] rdata;
    logic rdy;
    logic err;
  } iqgom_st_t;

  iqgom_st_t q, d;
  iqgom_sel_t sel;
  logic setup;
  logic access;
  logic load;
  logic [3:0][10:0] ch_gain;
  logic [3:0][12:0] ch_ofs;
  logic [3:0][15:0] ch_in;
  logic [3:0][15:0] ch_res;
  logic [3:0] ch_vld;
  logic [31:0] rot_ab;
  logic [31:0] rot_cd;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode; anything off a word boundary is unmapped
  function automatic iqgom_sel_t reg_sel(input logic [7:0] a);
    if (a[1:0] != 2'h0) begin
      return SEL_NONE;
    end
    case (a[7:2])
      IDX_C_OFS: return SEL_C_OFS;
      IDX_D_OFS: return SEL_D_OFS;
      IDX_A_GAIN: return SEL_A_GAIN;
      IDX_MIX_B_GAIN: return SEL_MIX_B_GAIN;
      IDX_C_GAIN: return SEL_C_GAIN;
      IDX_AUTOSYNC: return SEL_AUTOSYNC;
      IDX_ACT_C_OFS: return SEL_ACT_C_OFS;
      IDX_ACT_D_OFS: return SEL_ACT_D_OFS;
      default: return SEL_NONE;
    endcase
  endfunction

  // Total phase step per sample in eighths of a turn
  function automatic logic [2:0] mix_step(input logic [3:0] m);
    logic [2:0] s;
    s = 3'h0;
    if (m[MIX_P8]) begin
      s = s + STEP_P8;
    end
    if (m[MIX_P4]) begin
      s = s + STEP_P4;
    end
    if (m[MIX_P2]) begin
      s = s + STEP_P2;
    end
    if (m[MIX_M4]) begin
      s = s + STEP_M4;
    end
    return s;
  endfunction

  // Rotate an I/Q pair by k eighths of a turn, quarter turns exact
  function automatic logic [31:0] rotate(input logic [2:0] k,
                                         input logic signed [15:0] i,
                                         input logic signed [15:0] qv);
    logic signed [17:0] a;
    logic signed [17:0] b;
    logic signed [17:0] ra;
    logic signed [17:0] rb;
    logic signed [35:0] pa;
    logic signed [35:0] pb;
    a = 18'(i);
    b = 18'(qv);
    pa = '0;
    pb = '0;
    case (k[2:1])
      2'h0: begin
        ra = a;
        rb = b;
      end
      2'h1: begin
        ra = -b;
        rb = a;
      end
      2'h2: begin
        ra = -a;
        rb = -b;
      end
      default: begin
        ra = b;
        rb = -a;
      end
    endcase
    // Odd steps add a 45 degree turn; costs two multipliers per pair
    if (k[0]) begin
      pa = (36'(ra) - 36'(rb)) * 36'(COS45_Q15);
      pb = (36'(ra) + 36'(rb)) * 36'(COS45_Q15);
      ra = 18'(pa >>> COS45_SHIFT);
      rb = 18'(pb >>> COS45_SHIFT);
    end
    return {iqgom_sat(20'(ra)), iqgom_sat(20'(rb))};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Per-channel correction; D gain is tied to unity (GAIN_RST) and the AB offsets to zero (OFS_RST)
  assign ch_gain[0] = q.chan_a_gain_value;
  assign ch_gain[1] = q.chan_b_gain_value;
  assign ch_gain[2] = q.chan_c_gain_value;
  assign ch_gain[3] = GAIN_RST;
  assign ch_ofs[0] = OFS_RST;
  assign ch_ofs[1] = OFS_RST;
  assign ch_ofs[2] = q.act_c_ofs;
  assign ch_ofs[3] = q.act_d_ofs;
  assign ch_in[0] = sample_a_in;
  assign ch_in[1] = sample_b_in;
  assign ch_in[2] = sample_c_in;
  assign ch_in[3] = sample_d_in;

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_chan
      iqgom_chan iqgom_chan_i (
        .pclk(pclk),
        .presetn(presetn),
        .gain(ch_gain[g]),
        .offset($signed(ch_ofs[g])),
        .sample($signed(ch_in[g])),
        .sample_valid(sample_valid_in),
        .result(ch_res[g]),
        .result_valid(ch_vld[g])
      );
    end
  endgenerate

  // Coarse mixer works on the AB and CD pairs with one shared phase
  assign rot_ab = rotate(q.phase, ch_res[0], ch_res[1]);
  assign rot_cd = rotate(q.phase, ch_res[2], ch_res[3]);

  assign sel = reg_sel(paddr);
  assign setup = psel & ~penable;
  assign access = psel & penable & q.rdy;

  ////////////////////////////////////////////////////////////////////////////
  // Next state: bus slave, offset sync and mixer stage
  always_comb begin
    d = q;
    load = sync_in;
    d.loaded = 1'b0;
    // Setup phase latches read data and error so the answer is a flop
    if (setup) begin
      d.rdy = 1'b1;
      d.err = (sel == SEL_NONE) ||
              (pwrite && (sel == SEL_ACT_C_OFS || sel == SEL_ACT_D_OFS));
      d.rdata = '0;
      case (sel)
        SEL_C_OFS: d.rdata[OFS_MSB:0] = q.chan_c_offset_value;
        SEL_D_OFS: d.rdata[OFS_MSB:0] = q.chan_d_offset_value;
        SEL_A_GAIN: d.rdata[GAIN_MSB:0] = q.chan_a_gain_value;
        SEL_MIX_B_GAIN: begin
          d.rdata[MIX_MSB:MIX_LSB] = q.cmix;
          d.rdata[GAIN_MSB:0] = q.chan_b_gain_value;
        end
        SEL_C_GAIN: d.rdata[GAIN_MSB:0] = q.chan_c_gain_value;
        SEL_AUTOSYNC: d.rdata[AUTOSYNC_BIT] = q.autosync;
        SEL_ACT_C_OFS: d.rdata[OFS_MSB:0] = q.act_c_ofs;
        SEL_ACT_D_OFS: d.rdata[OFS_MSB:0] = q.act_d_ofs;
        default: d.rdata = '0;
      endcase
      // Refused transfers return zero, also writes aimed at the read-only offsets
      if (d.err) begin
        d.rdata = '0;
      end
    end
    // Access phase completes here; writes land on this edge only
    if (access) begin
      d.rdy = 1'b0;
      d.err = 1'b0;
      if (pwrite && !q.err) begin
        case (sel)
          SEL_C_OFS: begin
            d.chan_c_offset_value = pwdata[OFS_MSB:0];
            if (q.autosync) begin
              load = 1'b1;
            end
          end
          SEL_D_OFS: d.chan_d_offset_value = pwdata[OFS_MSB:0];
          SEL_A_GAIN: d.chan_a_gain_value = pwdata[GAIN_MSB:0];
          SEL_MIX_B_GAIN: begin
            d.cmix = pwdata[MIX_MSB:MIX_LSB];
            d.chan_b_gain_value = pwdata[GAIN_MSB:0];
          end
          SEL_C_GAIN: d.chan_c_gain_value = pwdata[GAIN_MSB:0];
          SEL_AUTOSYNC: d.autosync = pwdata[AUTOSYNC_BIT];
          default: d.autosync = q.autosync;
        endcase
      end
    end
    // Both offsets move on the same edge, including a C value written now
    if (load) begin
      d.act_c_ofs = d.chan_c_offset_value;
      d.act_d_ofs = d.chan_d_offset_value;
      d.loaded = 1'b1;
    end
    // Mixer output stage; phase only advances with real samples
    d.out_vld = ch_vld[0];
    if (ch_vld[0]) begin
      d.out_a = rot_ab[31:16];
      d.out_b = rot_ab[15:0];
      d.out_c = rot_cd[31:16];
      d.out_d = rot_cd[15:0];
      d.phase = q.phase + mix_step(q.cmix);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register with documented reset values
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.chan_c_offset_value <= OFS_RST;
      q.chan_d_offset_value <= OFS_RST;
      q.chan_a_gain_value <= GAIN_RST;
      q.chan_b_gain_value <= GAIN_RST;
      q.chan_c_gain_value <= GAIN_RST;
      q.cmix <= MIX_RST;
      q.autosync <= AUTOSYNC_RST;
      q.act_c_ofs <= OFS_RST;
      q.act_d_ofs <= OFS_RST;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs straight from the state register
  assign prdata = q.rdata;
  assign pready = q.rdy;
  assign pslverr = q.err;
  assign sample_a_out = q.out_a;
  assign sample_b_out = q.out_b;
  assign sample_c_out = q.out_c;
  assign sample_d_out = q.out_d;
  assign sample_valid_out = q.out_vld;
  assign offset_loaded = q.loaded;

endmodule

// File: iqgom_regs_assertions.sv
`timescale 1ns/1ps
module iqgom_regs_assertions import iqgom_pkg::*; (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Offset load and samples
  input wire logic sync_in,
  input wire logic sample_valid_in,
  input wire logic sample_valid_out,
  input wire logic offset_loaded
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////////////////
  // Completed C offset write, the only bus cause of a load
  logic wr_c;
  assign wr_c = psel && penable && pready && pwrite && paddr == {IDX_C_OFS, 2'b00};
  // Bus steps
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_wr_d;
    psel && penable && pready && pwrite && paddr == {IDX_D_OFS, 2'b00} && !sync_in;
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  property p_rdy_next; s_setup |=> pready; endproperty
  a_rdy_next: assert property (p_rdy_next) else $error("ready late after setup");
  property p_rdy_one; pready |=> !pready; endproperty
  a_rdy_one: assert property (p_rdy_one) else $error("ready held too long");
  property p_err; pslverr |-> pready && prdata == 32'h0; endproperty
  a_err: assert property (p_err) else $error("error without ready or with data");
  property p_rd_hi; pready && !pwrite |-> prdata[31:16] == 16'h0; endproperty
  a_rd_hi: assert property (p_rd_hi) else $error("upper read bits set");
  property p_wr_d; s_wr_d |=> !offset_loaded; endproperty
  a_wr_d: assert property (p_wr_d) else $error("D write loaded offsets");
  property p_sync; sync_in |=> offset_loaded; endproperty
  a_sync: assert property (p_sync) else $error("sync gave no load");
  property p_ld; offset_loaded |-> $past(sync_in) || $past(wr_c); endproperty
  a_ld: assert property (p_ld) else $error("load without cause");
  property p_lat; sample_valid_in |-> ##2 sample_valid_out; endproperty
  a_lat: assert property (p_lat) else $error("sample latency wrong");
  property p_spur; sample_valid_out |-> $past(sample_valid_in, 2); endproperty
  a_spur: assert property (p_spur) else $error("spurious sample valid");
endmodule

bind iqgom_regs iqgom_regs_assertions iqgom_regs_assertions_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sync_in(sync_in),
  .sample_valid_in(sample_valid_in), .sample_valid_out(sample_valid_out),
  .offset_loaded(offset_loaded)
);

// File: test_iqgom_regs.sv
`timescale 1ns/1ps
module test_iqgom_regs import iqgom_pkg::*; ;
  // Design signals
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, sync_in = 1'b0, vin = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic pready, pslverr, rerr, vout, loaded;
  logic signed [15:0] sa = 16'h0, sb = 16'h0, sc = 16'h0, sd = 16'h0, oa, ob, oc, od;
  int failures = 0, compares = 0;
  // Clock
  always #25 pclk = ~pclk;
  iqgom_regs iqgom_regs_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sync_in(sync_in), .sample_a_in(sa), .sample_b_in(sb), .sample_c_in(sc),
    .sample_d_in(sd), .sample_valid_in(vin), .sample_a_out(oa), .sample_b_out(ob),
    .sample_c_out(oc), .sample_d_out(od), .sample_valid_out(vout), .offset_loaded(loaded)
  );
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One APB transfer; waits on pready, only the watchdog ends a hang
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] i, input logic [31:0] e);
    apb(1'b0, {i, 2'b00}, 32'h0);
    check(rdat, e);
    check(rerr, 1'b0);
  endtask
  task automatic wr(input logic [5:0] i, input logic [31:0] d);
    apb(1'b1, {i, 2'b00}, d);
  endtask
  // Sample packs are A, B, C, D from the top
  task automatic smp(input logic [63:0] i, input logic [63:0] e);
    @(posedge pclk);
    {sa, sb, sc, sd} <= i;
    vin <= 1'b1;
    @(posedge pclk);
    vin <= 1'b0;
    @(posedge pclk);
    #1 check({oa, ob}, e[63:32]);
    check({oc, od}, e[31:0]);
    check(vout, 1'b1);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rd(IDX_C_OFS, 32'h0);
    rd(IDX_D_OFS, 32'h0);
    rd(IDX_A_GAIN, 32'h400);
    rd(IDX_MIX_B_GAIN, 32'h400);
    rd(IDX_C_GAIN, 32'h400);
    rd(IDX_AUTOSYNC, 32'h0);
    rd(IDX_ACT_C_OFS, 32'h0);
    rd(IDX_ACT_D_OFS, 32'h0);
  endtask
  // All ones written; reserved bits must read back zero
  task automatic t_fields;
    wr(IDX_C_OFS, 32'hFFFFFFFF);
    rd(IDX_C_OFS, 32'h1FFF);
    wr(IDX_D_OFS, 32'hFFFFFFFF);
    rd(IDX_D_OFS, 32'h1FFF);
    wr(IDX_A_GAIN, 32'hFFFFFFFF);
    rd(IDX_A_GAIN, 32'h7FF);
    wr(IDX_MIX_B_GAIN, 32'hFFFFFFFF);
    rd(IDX_MIX_B_GAIN, 32'hF7FF);
    wr(IDX_C_GAIN, 32'hFFFFFFFF);
    rd(IDX_C_GAIN, 32'h7FF);
  endtask
  task automatic t_refuse;
    apb(1'b0, 8'h40, 32'h0);
    check(rerr, 1'b1);
    check(rdat, 32'h0);
    apb(1'b1, {IDX_ACT_C_OFS, 2'b00}, 32'h5);
    check(rerr, 1'b1);
    apb(1'b0, 8'h29, 32'h0);
    check(rerr, 1'b1);
    rd(IDX_ACT_C_OFS, 32'h0);
  endtask
  // Manual sync first, then the autosync path; D always before C
  task automatic t_sync;
    wr(IDX_D_OFS, 32'h7);
    wr(IDX_C_OFS, 32'h9);
    rd(IDX_ACT_D_OFS, 32'h0);
    rd(IDX_ACT_C_OFS, 32'h0);
    @(posedge pclk);
    sync_in <= 1'b1;
    @(posedge pclk);
    sync_in <= 1'b0;
    #1 check(loaded, 1'b1);
    rd(IDX_ACT_C_OFS, 32'h9);
    rd(IDX_ACT_D_OFS, 32'h7);
    wr(IDX_AUTOSYNC, 32'h1);
    wr(IDX_D_OFS, 32'h1FFD);
    #1 check(loaded, 1'b0);
    rd(IDX_ACT_D_OFS, 32'h7);
    wr(IDX_C_OFS, 32'h5);
    #1 check(loaded, 1'b1);
    rd(IDX_ACT_C_OFS, 32'h5);
    rd(IDX_ACT_D_OFS, 32'h1FFD);
    // Refused write to a nonzero read-only offset: error, zero data, no change
    apb(1'b1, {IDX_ACT_D_OFS, 2'b00}, 32'h0);
    check(rerr, 1'b1);
    check(rdat, 32'h0);
    rd(IDX_ACT_D_OFS, 32'h1FFD);
  endtask
  // Gains 1.5, 1.0, 0.5; C offset +5, D offset -3
  task automatic t_data;
    wr(IDX_A_GAIN, 32'h600);
    wr(IDX_MIX_B_GAIN, 32'h400);
    wr(IDX_C_GAIN, 32'h200);
    smp(64'hFC18_012C_03E8_7FFF, 64'hFA24_012C_01F9_7FFC);
    wr(IDX_C_GAIN, 32'h7FF);
    smp(64'h0000_0000_7FFF_8000, 64'h0000_0000_7FFF_8000);
  endtask
  // Half-rate shift flips sign each sample; +fs/4 with -fs/4 cancels out
  task automatic t_mix;
    wr(IDX_A_GAIN, 32'h400);
    wr(IDX_MIX_B_GAIN, 32'h2400);
    smp(64'h0064_0000_0000_0000, 64'h0064_0000_0005_FFFD);
    smp(64'h0064_0000_0000_0000, 64'hFF9C_0000_FFFB_0003);
    smp(64'h0064_0000_0000_0000, 64'h0064_0000_0005_FFFD);
    wr(IDX_MIX_B_GAIN, 32'h5400);
    smp(64'h0064_0000_0000_0000, 64'hFF9C_0000_FFFB_0003);
    smp(64'h0064_0000_0000_0000, 64'hFF9C_0000_FFFB_0003);
    // fs/8 alone: phase 4 then 5, the odd step takes the 45 degree path
    wr(IDX_MIX_B_GAIN, 32'h8400);
    smp(64'h0064_0000_0000_0000, 64'hFF9C_0000_FFFB_0003);
    smp(64'h0064_0000_0000_0000, 64'hFFB9_FFB9_FFFA_FFFE);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Second reset mid-run: registers, offsets and mixer phase start over
  task automatic t_rst2;
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    #1 check({pready, pslverr, vout, loaded}, 32'h0);
    t_reset();
    smp(64'h0064_0000_0000_0000, 64'h0064_0000_0000_0000);
  endtask
  task automatic wrap_up;
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_fields();
    t_refuse();
    t_sync();
    t_data();
    t_mix();
    t_rst2();
    wrap_up();
  end
  // Watchdog, far beyond the few hundred cycles needed
  initial begin
    #500000;
    failures++;
    wrap_up();
  end
endmodule
